/* rtl/afc_regs.v */
// angle filter configuration registers with wishbone slave
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "afc_defs.vh"
module afc_regs (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // wishbone slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [5:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // nonvolatile boot image
   input wire i_nv_load,
   input wire [15:0] i_nv_num2,
   input wire [15:0] i_nv_num3,
   input wire [15:0] i_nv_den2,
   input wire [7:0] i_nv_exp,
   input wire [3:0] i_nv_hcount,
   input wire [4:0] i_nv_high,
   input wire [191:0] i_nv_words,
   // field amplitude from the signal path
   input wire [15:0] i_amp,
   input wire i_amp_valid,
   // configuration to the signal path
   output reg signed [31:0] o_num2_scaled,
   output reg signed [31:0] o_num3_scaled,
   output reg [15:0] o_den2,
   output reg [3:0] o_hcount,
   output reg o_hlin_en,
   output reg o_lin_order,
   output reg [191:0] o_harm_coef,
   output reg o_harm_coef_valid,
   output reg [31:0] o_feature_default,
   // error flag and interrupt
   output reg o_field_high_error_flag,
   output reg o_irq
);
   // ***********************************************************
   // storage
   // ***********************************************************
   reg [15:0] num2_q;
   reg [15:0] num3_q;
   reg [15:0] den2_q;
   reg [7:0] exp_q;
   reg [3:0] hcount_q;
   reg [15:0] hlim_q;
   reg hlin_en_q;
   reg lin_order_q;
   reg [1:0] stat_q;
   reg [1:0] mask_q;
   reg [1:0] stat_d;
   reg flag_q;
   reg flag_d;
   reg [31:0] rdata;
   wire acc;
   wire wr;
   wire rd;
   wire [3:0] idx;
   wire over;
   wire signed [31:0] num2_s;
   wire signed [31:0] num3_s;
   wire [3:0] nv_hc_cap;
   wire [15:0] hlim_boot;
   // write strobes and merged write words
   wire wr_ok;
   wire wr_num2;
   wire wr_hnum3;
   wire wr_hlden2;
   wire wr_ctrl;
   wire wr_mask;
   wire rd_stat;
   wire [31:0] wm_num2;
   wire [31:0] wm_hnum3;
   wire [31:0] wm_hlden2;

   // byte-lane merge of a write with old contents
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] sel;
      integer k;
      begin
         merge = old_v;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               merge[k*8 +: 8] = new_v[k*8 +: 8];
            end
         end
      end
   endfunction

   // one register picked out by an access
   function hit;
      input acc_v;
      input [3:0] idx_v;
      input [3:0] reg_v;
      begin
         hit = acc_v && (idx_v == reg_v);
      end
   endfunction

   // ***********************************************************
   // bus decode
   // ***********************************************************
   assign acc = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr = acc && i_wb_we;
   assign rd = acc && !i_wb_we;
   assign idx = i_wb_adr[5:2];

   // per-register strobes, a boot load cycle drops writes
   assign wr_ok = wr && !i_nv_load;
   assign wr_num2 = hit(wr_ok, idx, `AFC_IDX_NUM2);
   assign wr_hnum3 = hit(wr_ok, idx, `AFC_IDX_HNUM3);
   assign wr_hlden2 = hit(wr_ok, idx, `AFC_IDX_HLDEN2);
   assign wr_ctrl = hit(wr_ok, idx, `AFC_IDX_CTRL);
   assign wr_mask = hit(wr_ok, idx, `AFC_IDX_MASK);

   // status read strobe, the read clears
   assign rd_stat = hit(rd, idx, `AFC_IDX_STAT);

   // ***********************************************************
   // write data merged into current contents
   // ***********************************************************
   // unselected lanes keep their old bits, padding reads as zero
   assign wm_num2 = merge({8'h00, exp_q, num2_q}, i_wb_dat, i_wb_sel);
   assign wm_hnum3 = merge({12'h000, hcount_q, num3_q}, i_wb_dat,
      i_wb_sel);
   assign wm_hlden2 = merge({hlim_q, den2_q}, i_wb_dat, i_wb_sel);

   // boot values: cap count, place the five stored limit bits
   assign nv_hc_cap = (i_nv_hcount > `AFC_HCNT_NV_MAX) ?
      `AFC_HCNT_NV_MAX : i_nv_hcount;
   assign hlim_boot = {5'h00, i_nv_high, 6'h00};

   // ***********************************************************
   // numerator scaling
   // ***********************************************************
   afc_sm_scale #(
      .W(16)
   ) u_num2 (
      .i_coef(num2_q),
      .i_exp(exp_q),
      .o_val(num2_s)
   );
   afc_sm_scale #(
      .W(16)
   ) u_num3 (
      .i_coef(num3_q),
      .i_exp(exp_q),
      .o_val(num3_s)
   );

   // high limit compare
   afc_hlimit u_hlim (
      .i_limit(hlim_q),
      .i_amp(i_amp),
      .o_over(over)
   );

   // ***********************************************************
   // read mux
   // ***********************************************************
   always @* begin
      case (idx)
         `AFC_IDX_NUM2: rdata = {8'h00, exp_q, num2_q};
         `AFC_IDX_HNUM3: rdata = {8'h00, 4'h0, hcount_q, num3_q};
         `AFC_IDX_HLDEN2: rdata = {hlim_q, den2_q};
         `AFC_IDX_CTRL: rdata = {30'h0, lin_order_q, hlin_en_q};
         `AFC_IDX_STAT: rdata = {30'h0, stat_q};
         `AFC_IDX_MASK: rdata = {30'h0, mask_q};
         default: rdata = 32'h0000_0000;
      endcase
   end

   // ***********************************************************
   // status: set wins over read-clear
   // ***********************************************************
   always @* begin
      stat_d = stat_q;
      if (rd_stat) begin
         stat_d = 2'b00;
      end
      if (i_amp_valid && over) begin
         stat_d[`AFC_ST_HIGH] = 1'b1;
      end
      if (i_nv_load) begin
         stat_d[`AFC_ST_BOOT] = 1'b1;
      end
   end

   // error flag follows each fresh amplitude sample
   always @* begin
      flag_d = flag_q;
      if (i_amp_valid) begin
         flag_d = over;
      end
   end

   // ***********************************************************
   // registers
   // ***********************************************************
   // bus answer one cycle after the request is taken
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= acc;
         o_wb_dat <= rd ? rdata : 32'h0000_0000;
      end
   end

   // sticky status and last sample flag
   always @(posedge i_clk) begin
      if (i_srst) begin
         stat_q <= 2'h0;
         flag_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         flag_q <= flag_d;
      end
   end

   // numerator two and shared exponent, boot load wins
   always @(posedge i_clk) begin
      if (i_srst) begin
         num2_q <= 16'h0000;
         exp_q <= 8'h00;
      end else if (i_nv_load) begin
         num2_q <= i_nv_num2;
         exp_q <= i_nv_exp;
      end else if (wr_num2) begin
         num2_q <= wm_num2[15:0];
         exp_q <= wm_num2[`AFC_EXP_LSB+7:`AFC_EXP_LSB];
      end
   end

   // harmonic count and numerator three
   always @(posedge i_clk) begin
      if (i_srst) begin
         hcount_q <= 4'h0;
         num3_q <= 16'h0000;
      end else if (i_nv_load) begin
         hcount_q <= nv_hc_cap;
         num3_q <= i_nv_num3;
      end else if (wr_hnum3) begin
         hcount_q <= wm_hnum3[`AFC_HCNT_MSB:`AFC_HCNT_LSB];
         num3_q <= wm_hnum3[15:0];
      end
   end

   // field high limit and denominator two
   always @(posedge i_clk) begin
      if (i_srst) begin
         hlim_q <= 16'h0000;
         den2_q <= 16'h0000;
      end else if (i_nv_load) begin
         hlim_q <= hlim_boot;
         den2_q <= i_nv_den2;
      end else if (wr_hlden2) begin
         hlim_q <= wm_hlden2[31:`AFC_HLIM_LSB];
         den2_q <= wm_hlden2[15:0];
      end
   end

   // control bits, low lane only
   always @(posedge i_clk) begin
      if (i_srst) begin
         hlin_en_q <= 1'b0;
         lin_order_q <= 1'b0;
      end else if (wr_ctrl && i_wb_sel[0]) begin
         hlin_en_q <= i_wb_dat[0];
         lin_order_q <= i_wb_dat[1];
      end
   end

   // interrupt mask, low lane only
   always @(posedge i_clk) begin
      if (i_srst) begin
         mask_q <= 2'h0;
      end else if (wr_mask && i_wb_sel[0]) begin
         mask_q <= i_wb_dat[1:0];
      end
   end

   // ***********************************************************
   // registered outputs
   // ***********************************************************
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_num2_scaled <= 32'sh0000_0000;
         o_num3_scaled <= 32'sh0000_0000;
         o_den2 <= 16'h0000;
         o_hcount <= 4'h0;
         o_hlin_en <= 1'b0;
         o_lin_order <= 1'b0;
         o_harm_coef <= {192{1'b0}};
         o_harm_coef_valid <= 1'b0;
         o_feature_default <= 32'h0000_0000;
         o_field_high_error_flag <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_num2_scaled <= num2_s;
         o_num3_scaled <= num3_s;
         o_den2 <= den2_q;
         o_hcount <= hlin_en_q ? hcount_q : 4'h0;
         o_hlin_en <= hlin_en_q;
         o_lin_order <= lin_order_q;
         o_field_high_error_flag <= flag_d;
         o_irq <= |(stat_d & mask_q);
         if (i_nv_load) begin
            // count ten or eleven turns six words into coefficients
            if (nv_hc_cap >= `AFC_HCNT_REPURPOSE) begin
               o_harm_coef <= i_nv_words;
               o_harm_coef_valid <= 1'b1;
               o_feature_default <= `AFC_FEATURE_DEFAULT;
            end else begin
               o_harm_coef <= {192{1'b0}};
               o_harm_coef_valid <= 1'b0;
               o_feature_default <= i_nv_words[31:0];
            end
         end
      end
   end
endmodule // afc_regs

/* rtl/afc_defs.vh */
// constants for the angle filter configuration register bank
`ifndef AFC_DEFS_VH
`define AFC_DEFS_VH
// register offsets (index, taken from byte address bits 5:2)
`define AFC_IDX_HNUM3 4'h9
`define AFC_IDX_HLDEN2 4'hA
`define AFC_IDX_NUM2 4'h8
`define AFC_IDX_CTRL 4'hC
`define AFC_IDX_STAT 4'hD
`define AFC_IDX_MASK 4'hE
`define AFC_IDX_BOOT 4'hF
// field positions
`define AFC_SIGN_BIT 15
`define AFC_MAG_MSB 14
`define AFC_EXP_LSB 16
`define AFC_HCNT_LSB 16
`define AFC_HCNT_MSB 19
`define AFC_HLIM_LSB 16
`define AFC_NVHL_LSB 22
`define AFC_NVHL_MSB 26
// limits and boot values
`define AFC_HCNT_NV_MAX 4'hB
`define AFC_HCNT_REPURPOSE 4'hA
`define AFC_NV_WORD_FIRST 5'h15
`define AFC_NV_WORD_LAST 5'h1A
`define AFC_FEATURE_DEFAULT 32'h0000_0000
// status bit positions
`define AFC_ST_HIGH 0
`define AFC_ST_BOOT 1
`endif

/* rtl/afc_sm_scale.v */
// sign-magnitude coefficient scaled by the shared exponent
`timescale 1ns/1ps
module afc_sm_scale #(
   parameter W = 16
) (
   // coefficient and exponent
   input wire [W-1:0] i_coef,
   input wire [7:0] i_exp,
   // signed scaled value, sixteen fraction bits below the point
   output wire signed [W+15:0] o_val
);
   wire [W+15:0] mag_ext;
   wire [W+15:0] mag_sh;
   // magnitude extended then shifted right by the exponent
   assign mag_ext = {1'b0, i_coef[W-2:0], 16'h0000};
   assign mag_sh = (i_exp > 8'h1F) ? {(W+16){1'b0}} : (mag_ext >> i_exp);
   // sign bit negates
   assign o_val = i_coef[W-1] ? -$signed(mag_sh) : $signed(mag_sh);
endmodule // afc_sm_scale

/* rtl/afc_hlimit.v */
// field amplitude high limit comparator
`timescale 1ns/1ps
module afc_hlimit (
   // limit and amplitude
   input wire [15:0] i_limit,
   input wire [15:0] i_amp,
   // combinational over-limit indication
   output wire o_over
);
   // zero disables the check
   assign o_over = (i_limit != 16'h0000) && (i_amp > i_limit);
endmodule // afc_hlimit

/* verif/afc_regs_props.sv */
// assertion checker for the angle filter register bank
`timescale 1ns/1ps
module afc_regs_props (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // bus
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire [5:0] i_wb_adr,
   input wire [31:0] o_wb_dat,
   input wire o_wb_ack,
   // field check and count
   input wire i_amp_valid,
   input wire o_field_high_error_flag,
   input wire [3:0] o_hcount,
   input wire o_hlin_en
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // bus answer timing
   a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_ack_next_cycle: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack)
      |=> o_wb_ack) else $error("no ack one cycle after request");
   a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data outside ack");
   // read-back layout
   a_count_pad_zero: assert property (o_wb_ack &&
      $past(i_wb_adr[5:2]) == 4'h9 |-> o_wb_dat[31:20] == 12'h000)
      else $error("count padding not zero");
   a_exp_pad_zero: assert property (o_wb_ack &&
      $past(i_wb_adr[5:2]) == 4'h8 |-> o_wb_dat[31:24] == 8'h00)
      else $error("exponent padding not zero");
   a_unmapped_zero: assert property (o_wb_ack &&
      $past(i_wb_adr[5:2]) == 4'h0 |-> o_wb_dat == 32'h0)
      else $error("unmapped read not zero");
   // flag and count gating
   a_flag_on_sample: assert property (!i_amp_valid
      |=> $stable(o_field_high_error_flag))
      else $error("flag moved without sample");
   a_count_gated: assert property (!o_hlin_en && !$past(o_hlin_en)
      |-> o_hcount == 4'h0) else $error("count seen while disabled");
endmodule // afc_regs_props
bind afc_regs afc_regs_props u_props (.*);

/* verif/tb_afc_regs.sv */
// self-checking bench for the angle filter register bank
`timescale 1ns/1ps
module tb_afc_regs;
   reg i_clk = 0, i_srst = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
   reg i_nv_load = 0, i_amp_valid = 0;
   reg [5:0] i_wb_adr = 0;
   reg [3:0] i_wb_sel = 0, i_nv_hcount = 0;
   reg [31:0] i_wb_dat = 0, rd;
   reg [15:0] i_nv_num2 = 0, i_nv_num3 = 0, i_nv_den2 = 0, i_amp = 0;
   reg [7:0] i_nv_exp = 0;
   reg [4:0] i_nv_high = 0;
   reg [191:0] i_nv_words = 0;
   wire [31:0] o_wb_dat, o_num2_scaled, o_num3_scaled, o_feature_default;
   wire o_wb_ack, o_hlin_en, o_lin_order, o_harm_coef_valid, o_irq;
   wire o_field_high_error_flag;
   wire [15:0] o_den2;
   wire [3:0] o_hcount;
   wire [191:0] o_harm_coef;
   integer n_fail = 0, n_compared = 0;
   afc_regs u_dut (.*);
   // clock
   initial begin
      forever #50 i_clk = ~i_clk;
   end
   task end_of_test;
      begin
         $display("compared %0d failed %0d", n_compared, n_fail);
         if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
         end
      end
   endtask
   task chkb(input e, input g);
      chk({31'h0, e}, {31'h0, g});
   endtask
   // one wishbone cycle, bounded wait for ack
   task wb(input we, input [3:0] idx, input [31:0] d, input [3:0] s);
      integer k;
      begin
         @(posedge i_clk);
         i_wb_cyc <= 1;
         i_wb_stb <= 1;
         i_wb_we <= we;
         i_wb_adr <= {idx, 2'b00};
         i_wb_sel <= s;
         i_wb_dat <= d;
         k = 0;
         do begin
            @(posedge i_clk);
            k = k + 1;
         end while (o_wb_ack !== 1'b1 && k < 16);
         if (o_wb_ack !== 1'b1) begin
            n_fail = n_fail + 1;
            end_of_test;
         end
         rd = o_wb_dat;
         i_wb_cyc <= 0;
         i_wb_stb <= 0;
         i_wb_we <= 0;
      end
   endtask
   task wr(input [3:0] idx, input [31:0] d);
      wb(1, idx, d, 4'hF);
   endtask
   task rdc(input [3:0] idx, input [31:0] e);
      begin
         wb(0, idx, 32'h0, 4'hF);
         chk(e, rd);
      end
   endtask
   task settle;
      repeat (3) @(posedge i_clk);
   endtask
   // one amplitude sample
   task amp(input [15:0] a);
      begin
         @(posedge i_clk);
         i_amp <= a;
         i_amp_valid <= 1;
         @(posedge i_clk);
         i_amp_valid <= 0;
         settle;
      end
   endtask
   // boot load with a chosen stored count, other images unchanged
   task nvboot(input [3:0] hc);
      begin
         @(posedge i_clk);
         i_nv_hcount <= hc;
         i_nv_load <= 1;
         @(posedge i_clk);
         i_nv_load <= 0;
         settle;
      end
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge i_clk);
      i_srst <= 0;
      @(posedge i_clk);
      i_nv_num2 <= 16'h8003;
      i_nv_num3 <= 16'h0004;
      i_nv_den2 <= 16'hC001;
      i_nv_exp <= 8'h02;
      i_nv_hcount <= 4'hF;
      i_nv_high <= 5'h1F;
      i_nv_words <= {32'h6666_0006, 128'h0, 32'h1111_0001};
      i_nv_load <= 1;
      @(posedge i_clk);
      i_nv_load <= 0;
      settle;
      rdc(4'h8, 32'h0002_8003);
      rdc(4'h9, 32'h000B_0004);
      rdc(4'hA, 32'h07C0_C001);
      chk(32'hFFFF_4000, o_num2_scaled);
      chk(32'h0001_0000, o_num3_scaled);
      chk(32'h0000_C001, {16'h0, o_den2});
      chkb(1, o_harm_coef_valid);
      chk(32'h1111_0001, o_harm_coef[31:0]);
      chk(32'h6666_0006, o_harm_coef[191:160]);
      chk(32'h0, o_feature_default);
      chkb(0, o_irq);
      rdc(4'hD, 32'h2);
      wr(4'h9, 32'hFFFF_1234);
      rdc(4'h9, 32'h000F_1234);
      wr(4'hC, 32'h3);
      settle;
      chk(32'hF, {28'h0, o_hcount});
      chkb(1, o_hlin_en);
      chkb(1, o_lin_order);
      rdc(4'hC, 32'h3);
      wr(4'hC, 32'h0);
      settle;
      chk(32'h0, {28'h0, o_hcount});
      chkb(0, o_lin_order);
      wb(1, 4'hA, 32'hFFFF_0005, 4'h3);
      rdc(4'hA, 32'h07C0_0005);
      wr(4'h8, 32'h0000_0001);
      settle;
      chk(32'h0001_0000, o_num2_scaled);
      wr(4'h8, 32'h0001_8001);
      settle;
      chk(32'hFFFF_8000, o_num2_scaled);
      wr(4'hE, 32'h1);
      wr(4'hA, 32'h0100_0000);
      amp(16'h0100);
      chkb(0, o_field_high_error_flag);
      amp(16'h0101);
      chkb(1, o_field_high_error_flag);
      chkb(1, o_irq);
      rdc(4'hD, 32'h1);
      settle;
      chkb(0, o_irq);
      wr(4'hA, 32'h0);
      amp(16'hFFFF);
      chkb(0, o_field_high_error_flag);
      wr(4'hA, 32'h0001_0000);
      amp(16'h0002);
      chkb(1, o_field_high_error_flag);
      wr(4'h0, 32'hFFFF_FFFF);
      rdc(4'h0, 32'h0);
      nvboot(4'h9);
      rdc(4'h9, 32'h0009_0004);
      rdc(4'hA, 32'h07C0_C001);
      chkb(0, o_harm_coef_valid);
      chk(32'h1111_0001, o_feature_default);
      chk(32'h0, o_harm_coef[31:0]);
      nvboot(4'hA);
      rdc(4'h9, 32'h000A_0004);
      chkb(1, o_harm_coef_valid);
      chk(32'h0, o_feature_default);
      end_of_test;
   end
endmodule // tb_afc_regs
